// ===== design/pbmux_regs.vh
`ifndef PBMUX_REGS_VH
`define PBMUX_REGS_VH

// ----------------------------------------------------------------------------
// Parallel port mode codes and field positions
// ----------------------------------------------------------------------------
`define PBMUX_MODE_W 2
`define PBMUX_MODE_MEM_LO 2'h0
`define PBMUX_MODE_MEM_HI 2'h1
`define PBMUX_MODE_SEL_BIT 1
`define PBMUX_NUM_IRQ 5
`define PBMUX_NUM_GPIO 8
`define PBMUX_GPIO_CKE_BIT 4
`define PBMUX_BOOT_W 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PBMUX_PC_W 24
`define PBMUX_RESET_VECTOR 24'hff8000
`define PBMUX_GPIO_DIR_RST 8'h00
`define PBMUX_GPIO_OUT_RST 8'h00
`define PBMUX_IRQ_EN_RST 5'h00
`define PBMUX_FLAG_RST 1'h1

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define PBMUX_CORE_CLOCK_OUT_DIV 1
`define PBMUX_BOOT_WAIT 2'h2
`define PBMUX_BOOT_DONE 2'h3

`endif

// ===== design/pbmux_sync2.v
// ----------------------------------------------------------------------------
// Two-stage synchroniser for a bus of pin levels
// ----------------------------------------------------------------------------
module pbmux_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta_q;

  // The first stage is read only by the second one.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule // pbmux_sync2

// ===== design/pbmux_top.v
// Function
// - Boot-select pin at reset sets pins: high memory outputs, low host/IO inputs.
// - Modes 00/01 drive SDRAM column strobe; modes 10/11 make host select input.
// - Modes 00/01 drive SDRAM write enable; otherwise pin is host strobe one.
// - Modes 00/01 route SDRAM A10; modes 10/11 route general I/O thirteen.
// - A10 carries address bit A12 on activate, disables auto-precharge on access.
// - Modes 00/01 output SDRAM clock; modes 10/11 make host strobe two input.
// - Five active-low interrupt inputs, masked and prioritised by enable and mode.
// - Reset low halts execution, PC forced to FF8000h, fetch starts there.
// - Bit I/O lines individually in or out, outputs set/clear; inputs after reset.
// - After reset the four lowest bit I/O lines are sampled as boot mode.
// - Select 1 with enable 1 drives SDRAM clock-enable on bit I/O line four.
// - Select 0 with enable 1 drives SDRAM clock-enable on the flag pin.
// - Flag set by set instruction, cleared by clear or status load; high at reset.
// - Output-disable low floats clock out and flag; crystal output keeps driving.
// - Clock output toggles at machine-cycle rate.
// - Clock-generator idle turns oscillator input pin into output driven low.
`include "pbmux_regs.vh"

module pbmux_top (
  input wire clk,
  input wire sys_rst,
  // Reset pin, boot strap and output-disable pin.
  input wire reset_pin_n,
  input wire boot_select_pin,
  input wire out_disable_n,
  // Configuration from the bus selection logic and core.
  input wire [1:0] port_mode,
  input wire cke_select,
  input wire cke_enable,
  input wire irq_mode,
  input wire [4:0] irq_enable_reg,
  input wire irq_clear,
  input wire clockgen_idle_mode,
  // Memory interface function values.
  input wire sdram_col_strobe_n,
  input wire sdram_write_enable_n,
  input wire row_activate_cmd,
  input wire sdram_rw_cmd,
  input wire addr_bit_twelve,
  input wire sdram_interface_clock,
  input wire sdram_clock_enable,
  // General I/O thirteen as seen by the core.
  input wire general_io_thirteen,
  input wire gio13_dir_out,
  // Bit I/O control: direction, per-line set and clear strobes.
  input wire [7:0] gpio_dir_wr_data,
  input wire gpio_dir_wr,
  input wire [7:0] gpio_set,
  input wire [7:0] gpio_clr,
  // Flag control.
  input wire flag_set_instr,
  input wire flag_clear_instr,
  input wire status_reg_one_load,
  // Shared pins as input, output and output enable; flag and clock out have no input, crystal out only an enable.
  input wire cas_pin_i,
  output wire cas_pin_o,
  output wire cas_pin_oe,
  input wire we_pin_i,
  output wire we_pin_o,
  output wire we_pin_oe,
  input wire a10_pin_i,
  output wire a10_pin_o,
  output wire a10_pin_oe,
  input wire clkmem_pin_i,
  output wire clkmem_pin_o,
  output wire clkmem_pin_oe,
  input wire [7:0] gpio_pin_i,
  output wire [7:0] gpio_pin_o,
  output wire [7:0] gpio_pin_oe,
  output wire flag_pin_o,
  output wire flag_pin_oe,
  output wire core_clock_out,
  output wire core_clock_out_oe,
  input wire osc_clock_in_i,
  output wire osc_clock_in_o,
  output wire osc_clock_in_oe,
  output wire osc_crystal_out_oe,
  // Host and core side results.
  input wire [4:0] irq_pins_n,
  output reg host_port_select_n,
  output reg host_strobe_one_n,
  output reg host_strobe_two_n,
  output reg general_io_thirteen_in,
  output reg [7:0] gpio_in,
  output reg [3:0] boot_mode,
  output reg boot_mode_valid,
  output reg irq_req,
  output reg [2:0] irq_num,
  output reg [4:0] irq_pending,
  output reg cpu_halt,
  output reg [23:0] pc_load_value,
  output reg pc_load,
  output wire external_flag_out
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire [18:0] sync_in;
  wire [18:0] sync_out;
  wire rst_pin_s;
  wire oe_n_s;
  wire hcs_s;
  wire hds1_s;
  wire hds2_s;
  wire gio13_s;
  wire [7:0] gpio_s;
  wire [4:0] irq_s_n;

  assign sync_in = {reset_pin_n, out_disable_n, cas_pin_i, we_pin_i,
                    clkmem_pin_i, a10_pin_i, gpio_pin_i, irq_pins_n};

  pbmux_sync2 #(
    .W(19)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign {rst_pin_s, oe_n_s, hcs_s, hds1_s, hds2_s, gio13_s} = sync_out[18:13];
  assign gpio_s = sync_out[12:5];
  assign irq_s_n = sync_out[4:0];

  // --------------------------------------------------------------------------
  // Power-up direction and mode decode
  // --------------------------------------------------------------------------
  reg strap_meta_q;
  reg strap_q;
  wire mem_mode;

  // The strap needs a known level while reset holds, so its flop pair is never reset.
  always @(posedge clk)
  begin
    strap_meta_q <= boot_select_pin;
    strap_q <= strap_meta_q;
  end

  // Reset holds the strap direction; after release the pins follow the mode field.
  assign mem_mode = !sys_rst & (port_mode[`PBMUX_MODE_SEL_BIT] == 1'b0);

  // --------------------------------------------------------------------------
  // Shared parallel bus pins
  // --------------------------------------------------------------------------
  reg a10_d;

  // A10 mirrors A12 on an activate, is held high to disable auto-precharge on access.
  always @*
  begin
    a10_d = 1'b0;
    if (row_activate_cmd)
      a10_d = addr_bit_twelve;
    else if (sdram_rw_cmd)
      a10_d = 1'b1;
  end

  assign cas_pin_o = sdram_col_strobe_n;
  assign cas_pin_oe = mem_mode | (sys_rst & strap_q);
  assign we_pin_o = sdram_write_enable_n;
  assign we_pin_oe = cas_pin_oe;
  assign a10_pin_o = mem_mode ? a10_d : general_io_thirteen;
  assign a10_pin_oe = cas_pin_oe | (!mem_mode & !sys_rst & gio13_dir_out);
  assign clkmem_pin_o = sdram_interface_clock;
  assign clkmem_pin_oe = cas_pin_oe;

  // Host select and strobes read idle-high, general I/O thirteen reads low, while the pins serve memory.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      host_port_select_n <= 1'b1;
      host_strobe_one_n <= 1'b1;
      host_strobe_two_n <= 1'b1;
      general_io_thirteen_in <= 1'b0;
    end
    else
    begin
      host_port_select_n <= mem_mode ? 1'b1 : hcs_s;
      host_strobe_one_n <= mem_mode ? 1'b1 : hds1_s;
      host_strobe_two_n <= mem_mode ? 1'b1 : hds2_s;
      general_io_thirteen_in <= mem_mode ? 1'b0 : gio13_s;
    end
  end

  // --------------------------------------------------------------------------
  // Bit I/O lines
  // --------------------------------------------------------------------------
  reg [7:0] gpio_dir_q;
  reg [7:0] gpio_out_q;
  wire cke_on_gpio;
  wire cke_on_flag;

  assign cke_on_gpio = cke_enable & cke_select;
  assign cke_on_flag = cke_enable & !cke_select;

  genvar gi;
  generate
    for (gi = 0; gi < `PBMUX_NUM_GPIO; gi = gi + 1)
    begin : g_gpio
      // Set wins over clear when both arrive together on one line.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          gpio_dir_q[gi] <= 1'b0;
          gpio_out_q[gi] <= 1'b0;
        end
        else
        begin
          if (gpio_dir_wr)
            gpio_dir_q[gi] <= gpio_dir_wr_data[gi];
          if (gpio_set[gi])
            gpio_out_q[gi] <= 1'b1;
          else if (gpio_clr[gi])
            gpio_out_q[gi] <= 1'b0;
        end
      end
      if (gi == `PBMUX_GPIO_CKE_BIT)
      begin : g_cke
        assign gpio_pin_o[gi] = cke_on_gpio ? sdram_clock_enable : gpio_out_q[gi];
        assign gpio_pin_oe[gi] = cke_on_gpio | gpio_dir_q[gi];
      end
      else
      begin : g_plain
        assign gpio_pin_o[gi] = gpio_out_q[gi];
        assign gpio_pin_oe[gi] = gpio_dir_q[gi];
      end
    end
  endgenerate

  // Boot mode is caught once the synchronised lines hold pin levels, not reset zeros.
  reg [1:0] boot_wait_q;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      gpio_in <= 8'h00;
      boot_mode <= 4'h0;
      boot_mode_valid <= 1'b0;
      boot_wait_q <= 2'h0;
    end
    else
    begin
      gpio_in <= gpio_s;
      if (boot_wait_q != `PBMUX_BOOT_DONE)
        boot_wait_q <= boot_wait_q + 2'h1;
      if (boot_wait_q == `PBMUX_BOOT_WAIT)
      begin
        boot_mode <= gpio_s[`PBMUX_BOOT_W-1:0];
        boot_mode_valid <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // External flag
  // --------------------------------------------------------------------------
  reg flag_q;

  // Set has priority, so a set in the same cycle as a clear is not lost.
  always @(posedge clk)
  begin
    if (sys_rst)
      flag_q <= `PBMUX_FLAG_RST;
    else if (flag_set_instr)
      flag_q <= 1'b1;
    else if (flag_clear_instr | status_reg_one_load)
      flag_q <= 1'b0;
  end

  assign external_flag_out = flag_q;
  assign flag_pin_o = cke_on_flag ? sdram_clock_enable : flag_q;
  assign flag_pin_oe = oe_n_s;

  // --------------------------------------------------------------------------
  // Clock pins
  // --------------------------------------------------------------------------
  reg core_clock_out_q;

  // Machine cycle equals the core clock here, so the pin toggles each rising edge.
  always @(posedge clk)
  begin
    if (sys_rst)
      core_clock_out_q <= 1'b0;
    else
      core_clock_out_q <= ~core_clock_out_q;
  end

  assign core_clock_out = core_clock_out_q;
  assign core_clock_out_oe = oe_n_s;
  assign osc_crystal_out_oe = 1'b1;
  assign osc_clock_in_o = 1'b0;
  assign osc_clock_in_oe = clockgen_idle_mode;

  // --------------------------------------------------------------------------
  // Reset pin and program counter
  // --------------------------------------------------------------------------
  reg rst_pin_prev_q;

  // Halt follows the pin; the vector load is one pulse on the rising edge.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rst_pin_prev_q <= 1'b0;
      cpu_halt <= 1'b1;
      pc_load <= 1'b0;
      pc_load_value <= `PBMUX_RESET_VECTOR;
    end
    else
    begin
      rst_pin_prev_q <= rst_pin_s;
      cpu_halt <= !rst_pin_s;
      pc_load <= rst_pin_s & !rst_pin_prev_q;
      pc_load_value <= `PBMUX_RESET_VECTOR;
    end
  end

  // --------------------------------------------------------------------------
  // External interrupts
  // --------------------------------------------------------------------------
  reg [4:0] pend_d;
  reg [4:0] masked;
  reg [2:0] num_d;
  reg [4:0] irq_prev_n_q;
  integer k;

  // Falling edges latch pending; an edge beats a clear in the same cycle.
  // Mode 0 favours line 0, mode 1 favours line 4.
  always @*
  begin
    pend_d = irq_clear ? 5'h00 : irq_pending;
    pend_d = pend_d | (irq_prev_n_q & ~irq_s_n);
    masked = pend_d & irq_enable_reg;
    num_d = 3'h0;
    for (k = `PBMUX_NUM_IRQ - 1; k >= 0; k = k - 1)
    begin
      if (!irq_mode && masked[k])
        num_d = k[2:0];
      if (irq_mode && masked[4 - k])
        num_d = 3'h4 - k[2:0];
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_prev_n_q <= 5'h00; // Matches the synchroniser reset level, so no false edge.
      irq_pending <= 5'h00;
      irq_req <= 1'b0;
      irq_num <= 3'h0;
    end
    else
    begin
      irq_prev_n_q <= irq_s_n;
      irq_pending <= pend_d;
      irq_req <= |masked;
      irq_num <= num_d;
    end
  end

endmodule // pbmux_top

// ===== tb/pbmux_monitor.sv
// ----------------------------------------
// Pin mux and control pin checker
// ----------------------------------------
module pbmux_monitor (
  input wire clk,
  input wire sys_rst,
  input wire reset_pin_n,
  input wire out_disable_n,
  input wire [1:0] port_mode,
  input wire cke_select,
  input wire cke_enable,
  input wire clockgen_idle_mode,
  input wire sdram_col_strobe_n,
  input wire sdram_write_enable_n,
  input wire sdram_interface_clock,
  input wire sdram_clock_enable,
  input wire flag_set_instr,
  input wire flag_clear_instr,
  input wire cas_pin_o,
  input wire cas_pin_oe,
  input wire we_pin_o,
  input wire we_pin_oe,
  input wire clkmem_pin_o,
  input wire clkmem_pin_oe,
  input wire [7:0] gpio_pin_o,
  input wire [7:0] gpio_pin_oe,
  input wire flag_pin_o,
  input wire flag_pin_oe,
  input wire core_clock_out,
  input wire core_clock_out_oe,
  input wire osc_clock_in_o,
  input wire osc_clock_in_oe,
  input wire osc_crystal_out_oe,
  input wire [23:0] pc_load_value,
  input wire pc_load,
  input wire external_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] age_q;
  wire mem = !port_mode[1] && age_q == 2'h3;
  wire host = port_mode[1] && age_q == 2'h3;
  // Edges since reset, held at three; the mode and clock checks wait out the first three.
  always @(posedge clk)
    age_q <= sys_rst ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_off;
    !out_disable_n [*3];
  endsequence
  sequence s_rel;
    $rose(reset_pin_n);
  endsequence
  a_cas_mux: assert property (mem |-> cas_pin_oe && cas_pin_o == sdram_col_strobe_n)
    else $error("column strobe pin wrong");
  a_mem_pins: assert property (mem |-> we_pin_oe && we_pin_o == sdram_write_enable_n
    && clkmem_pin_oe && clkmem_pin_o == sdram_interface_clock)
    else $error("memory pins wrong");
  a_host_float: assert property (host |-> !cas_pin_oe && !we_pin_oe && !clkmem_pin_oe)
    else $error("host pins driven");
  a_flag_clr: assert property (flag_clear_instr && !flag_set_instr |=> !external_flag_out)
    else $error("flag not cleared");
  a_cke_flag: assert property (cke_enable && !cke_select |-> flag_pin_o == sdram_clock_enable)
    else $error("flag pin not clock enable");
  a_cke_gpio: assert property (cke_enable && cke_select && age_q[1]
    |-> gpio_pin_oe[4] && gpio_pin_o[4] == sdram_clock_enable)
    else $error("line four not clock enable");
  a_clk_tog: assert property (age_q == 2'h3 |-> core_clock_out != $past(core_clock_out))
    else $error("clock out not toggling");
  a_off_float: assert property (s_off |-> !flag_pin_oe && !core_clock_out_oe
    && osc_crystal_out_oe)
    else $error("output disable wrong");
  a_idle_drv: assert property (clockgen_idle_mode |-> osc_clock_in_oe && !osc_clock_in_o)
    else $error("idle clock pin wrong");
  a_pc_load: assert property (s_rel |-> ##[1:4] pc_load && pc_load_value == 24'hff8000)
    else $error("no reset vector load");
endmodule // pbmux_monitor

bind pbmux_top pbmux_monitor u_mon (.*);

// ===== tb/pbmux_host.sv
// ----------------------------------------
// Host side of the shared pins
// ----------------------------------------
module pbmux_host (
  input wire clk,
  input wire go,
  input wire cas_oe,
  input wire cas_o,
  input wire we_oe,
  input wire we_o,
  input wire ck_oe,
  input wire ck_o,
  output wire cas_pin,
  output wire we_pin,
  output wire ck_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q = 3'h0;
  wire sel_n = cnt_q == 3'h0;
  wire stb_n = !(cnt_q >= 3'h2 && cnt_q <= 3'h5);
  // One access: select first, strobes inside it, select dropped last.
  always @(posedge clk)
  begin
    if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
    else if (go)
      cnt_q <= 3'h7;
  end
  // The host drives what the device releases; both strobes share its timing.
  assign cas_pin = cas_oe ? cas_o : sel_n;
  assign we_pin = we_oe ? we_o : stb_n;
  assign ck_pin = ck_oe ? ck_o : stb_n;
endmodule // pbmux_host

// ===== tb/test_parallel_bus_pin_mux_and_control_pins.sv
// ----------------------------------------
// Bench for the pin mux block
// ----------------------------------------
module test_parallel_bus_pin_mux_and_control_pins;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin_n, boot_select_pin, out_disable_n, cke_select, cke_enable, irq_mode;
  logic irq_clear, clockgen_idle_mode, sdram_col_strobe_n, sdram_write_enable_n;
  logic row_activate_cmd, sdram_rw_cmd, addr_bit_twelve, sdram_interface_clock;
  logic sdram_clock_enable, general_io_thirteen, gio13_dir_out, gpio_dir_wr;
  logic flag_set_instr, flag_clear_instr, status_reg_one_load, a10_pin_i, osc_clock_in_i;
  logic [1:0] port_mode;
  logic [4:0] irq_enable_reg, irq_pins_n, irq_pending;
  logic [7:0] gpio_dir_wr_data, gpio_set, gpio_clr, gpio_pin_i, gpio_pin_o, gpio_pin_oe, gpio_in;
  logic cas_pin_i, cas_pin_o, cas_pin_oe, we_pin_i, we_pin_o, we_pin_oe, a10_pin_o, a10_pin_oe;
  logic clkmem_pin_i, clkmem_pin_o, clkmem_pin_oe, flag_pin_o, flag_pin_oe, core_clock_out;
  logic core_clock_out_oe, osc_clock_in_o, osc_clock_in_oe, osc_crystal_out_oe;
  logic host_port_select_n, host_strobe_one_n, host_strobe_two_n, general_io_thirteen_in;
  logic boot_mode_valid, irq_req, cpu_halt, pc_load, external_flag_out, go, flag_m;
  logic [3:0] boot_mode;
  logic [2:0] irq_num;
  logic [23:0] pc_load_value;
  logic [7:0] out_m;
  int errors = 0;
  int num_checks = 0;
  int seed = 17904;
  int cyc = 0;
  int k;

  pbmux_top u_dut (.*);
  pbmux_host u_host (.clk(clk), .go(go), .cas_oe(cas_pin_oe), .cas_o(cas_pin_o),
    .we_oe(we_pin_oe), .we_o(we_pin_o), .ck_oe(clkmem_pin_oe), .ck_o(clkmem_pin_o),
    .cas_pin(cas_pin_i), .we_pin(we_pin_i), .ck_pin(clkmem_pin_i));

  // Free-running core clock.
  always #20 clk = ~clk;

  // A hang ends the run as a failure.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compares the pins with the model; the inputs seen are those of the last cycle.
  task automatic check_all();
    logic rt;
    rt = cke_enable & cke_select;
    chk(external_flag_out, flag_m);
    chk(flag_pin_o, (cke_enable & !cke_select) ? sdram_clock_enable : flag_m);
    chk(gpio_pin_o, rt ? {out_m[7:5], sdram_clock_enable, out_m[3:0]} : out_m);
    chk({cas_pin_oe, we_pin_oe, clkmem_pin_oe}, {3{!port_mode[1]}});
    if (!port_mode[1])
      chk({cas_pin_o, we_pin_o, clkmem_pin_o, a10_pin_o}, {sdram_col_strobe_n,
        sdram_write_enable_n, sdram_interface_clock, row_activate_cmd ? addr_bit_twelve : sdram_rw_cmd});
    else
      chk({a10_pin_oe, a10_pin_o & gio13_dir_out}, {gio13_dir_out,
        general_io_thirteen & gio13_dir_out});
  endtask

  // One random cycle; set wins over clear in both the flag and the lines.
  task automatic step();
    logic [31:0] rv;
    @(negedge clk);
    check_all();
    rv = $random(seed);
    {port_mode, cke_select, cke_enable, sdram_col_strobe_n, sdram_write_enable_n,
      row_activate_cmd, sdram_rw_cmd, addr_bit_twelve, sdram_interface_clock,
      sdram_clock_enable, general_io_thirteen, gio13_dir_out, flag_set_instr,
      flag_clear_instr, status_reg_one_load} = rv[14:0];
    {gpio_set, gpio_clr, gpio_pin_i, a10_pin_i, irq_mode} = rv[31:6];
    if (flag_set_instr)
      flag_m = 1'b1;
    else if (flag_clear_instr | status_reg_one_load)
      flag_m = 1'b0;
    out_m = (out_m & ~gpio_clr) | gpio_set;
  endtask

  // Directed scenarios first, then random traffic against the model.
  initial
  begin
    {boot_select_pin, cke_select, cke_enable, irq_mode, irq_clear, clockgen_idle_mode,
      row_activate_cmd, sdram_rw_cmd, addr_bit_twelve, sdram_interface_clock,
      sdram_clock_enable, general_io_thirteen, gio13_dir_out, gpio_dir_wr, go,
      flag_set_instr, flag_clear_instr, status_reg_one_load, a10_pin_i, osc_clock_in_i,
      port_mode, irq_enable_reg, gpio_dir_wr_data, gpio_set, gpio_clr, gpio_pin_i} = '0;
    {reset_pin_n, out_disable_n, sdram_col_strobe_n, sdram_write_enable_n} = 4'hf;
    irq_pins_n = 5'h1f;
    gpio_pin_i = 8'h5b;
    flag_m = 1'b1;
    out_m = 8'h00;
    repeat (4) @(negedge clk);
    chk({cas_pin_oe, external_flag_out}, 2'h1);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(gpio_pin_oe, 8'h00);
    chk({boot_mode_valid, boot_mode}, 5'h1b);
    chk(gpio_in, 8'h5b);
    port_mode = 2'h2;
    a10_pin_i = 1'b1;
    repeat (4) @(negedge clk);
    chk({host_port_select_n, host_strobe_one_n, host_strobe_two_n, general_io_thirteen_in}, 4'hf);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (6) @(negedge clk);
    chk({host_port_select_n, host_strobe_one_n, host_strobe_two_n}, 3'h0);
    for (int m = 0; m < 3; m++)
    begin
      irq_mode = m[0];
      irq_enable_reg = (m == 2) ? 5'h00 : 5'h1f;
      irq_clear = 1'b1;
      @(negedge clk);
      irq_clear = 1'b0;
      irq_pins_n = 5'h15;
      repeat (6) @(negedge clk);
      chk(irq_req, m != 2);
      chk(irq_pending, 5'h0a);
      if (m != 2)
        chk(irq_num, m ? 3 : 1);
      irq_pins_n = 5'h1f;
      @(negedge clk);
    end
    reset_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    chk(cpu_halt, 1);
    reset_pin_n = 1'b1;
    for (k = 0; k < 8 && pc_load !== 1'b1; k++)
      @(negedge clk);
    chk({pc_load, pc_load_value}, 25'h1ff8000);
    out_disable_n = 1'b0;
    clockgen_idle_mode = 1'b1;
    repeat (3) @(negedge clk);
    chk({flag_pin_oe, core_clock_out_oe, osc_crystal_out_oe}, 3'h1);
    chk({osc_clock_in_oe, osc_clock_in_o}, 2'h2);
    out_disable_n = 1'b1;
    clockgen_idle_mode = 1'b0;
    gpio_dir_wr_data = 8'hff;
    gpio_dir_wr = 1'b1;
    @(negedge clk);
    gpio_dir_wr = 1'b0;
    repeat (3) @(negedge clk);
    chk(gpio_pin_oe, 8'hff);
    repeat (80) step();
    // A second reset with the strap high must turn the shared pins into outputs.
    boot_select_pin = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    chk({cas_pin_oe, we_pin_oe, clkmem_pin_oe, a10_pin_oe, external_flag_out, cpu_halt}, 6'h3f);
    end_sim();
  end
endmodule // test_parallel_bus_pin_mux_and_control_pins
